// >>> odc_config.sv
module odc_config (
    input wire logic i_clock, // 100 MHz system clock
    input wire logic i_rst, // async reset, active high
    input wire logic i_req_valid, // one-cycle request strobe
    input wire odc_pkg::odc_req_s i_req, // decoded request
    input wire logic i_nv_valid, // nonvolatile contents valid (boot load)
    input wire logic [7:0] i_nv_power_on, // stored power-on pattern
    input wire logic [7:0] i_nv_fail_safe, // stored fail-safe pattern
    input wire logic i_out_cmd, // one-cycle: host output command taken
    input wire logic [7:0] i_out_value, // value of that output command
    input wire logic i_stalled, // same-domain stall indication
    input wire logic i_heartbeat_lost, // same-domain heartbeat timeout
    output logic o_rsp_valid, // one-cycle answer strobe
    output odc_pkg::odc_rsp_s o_rsp, // answer frame
    output logic o_nv_write, // one-cycle nonvolatile write strobe
    output odc_pkg::odc_nv_s o_nv, // nonvolatile write slot/data
    output logic [7:0] o_dout, // discrete output pattern
    output logic [7:0] o_analog_output // analog output code
);
    // stored copies mirror the nonvolatile cells
    logic [7:0] power_on;
    logic [7:0] fail_safe;
    logic [7:0] run_value;
    logic boot_loaded;
    odc_pkg::odc_mode_e mode;
    odc_pkg::odc_mode_e next_mode;

    // one decode for both codes keeps the selector filter identical for each
    function automatic logic odc_hit(input odc_pkg::odc_req_s req, input logic [7:0] code);
        return req.selector == odc_pkg::SEL_DOUT && req.func == code;
    endfunction

    // request decode; other selectors and codes are left to other handlers
    wire sel_ok = i_req.selector == odc_pkg::SEL_DOUT;
    wire hit_pon = i_req_valid && odc_hit(i_req, odc_pkg::FUNC_POWER_ON);
    wire hit_fsf = i_req_valid && odc_hit(i_req, odc_pkg::FUNC_FAIL_SAFE);
    wire is_set = !i_req.remote && i_req.length == odc_pkg::PATTERN_LEN;
    wire is_query = i_req.remote;
    wire set_pon = hit_pon && is_set;
    wire set_fsf = hit_fsf && is_set;
    wire answer = (hit_pon || hit_fsf) && (is_set || is_query);
    wire safe_cond = i_stalled || i_heartbeat_lost;

    // safe overrides the discrete outputs only; a command leaves boot for good
    // the safe state is never entered: stall and heartbeat loss act as an overlay in the mux
    always_comb begin
        next_mode = mode;
        case (mode)
            odc_pkg::ODC_BOOT: if (i_out_cmd) next_mode = odc_pkg::ODC_RUN;
            odc_pkg::ODC_RUN: next_mode = odc_pkg::ODC_RUN;
            odc_pkg::ODC_SAFE: if (i_out_cmd) next_mode = odc_pkg::ODC_RUN;
            default: next_mode = odc_pkg::ODC_BOOT;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mode <= odc_pkg::ODC_BOOT;
        end else begin
            mode <= next_mode;
        end
    end

    // the patterns load from nonvolatile memory once, then track host writes
    // boot_loaded stops a long i_nv_valid level from reloading over host writes
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            power_on <= odc_pkg::POWER_ON_RESET;
            fail_safe <= odc_pkg::FAIL_SAFE_RESET;
            boot_loaded <= 1'b0;
        end else begin
            // a write in the load cycle is already answered and committed, so it wins here
            if (i_nv_valid && !boot_loaded) begin
                power_on <= set_pon ? i_req.data : i_nv_power_on;
                fail_safe <= set_fsf ? i_req.data : i_nv_fail_safe;
                boot_loaded <= 1'b1;
            end else begin
                if (set_pon) power_on <= i_req.data;
                if (set_fsf) fail_safe <= i_req.data;
            end
        end
    end

    // boot pattern latched on power-on only, so a later write waits for reboot
    logic [7:0] boot_value;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            boot_value <= odc_pkg::POWER_ON_RESET;
            run_value <= odc_pkg::POWER_ON_RESET;
        end else begin
            if (i_nv_valid && !boot_loaded) boot_value <= i_nv_power_on;
            if (i_out_cmd) run_value <= i_out_value;
        end
    end

    // fail-safe is read live so a new value shows at once
    wire [7:0] next_dout = safe_cond ? fail_safe :
        (mode == odc_pkg::ODC_BOOT) ? boot_value : run_value;
    // analog outputs carry no fail-safe pattern, so they ignore the safe overlay
    wire [7:0] next_ao = (mode == odc_pkg::ODC_BOOT) ? boot_value : run_value;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_dout <= odc_pkg::POWER_ON_RESET;
            o_analog_output <= odc_pkg::POWER_ON_RESET;
        end else begin
            o_dout <= next_dout;
            o_analog_output <= next_ao;
        end
    end

    // answer and nonvolatile commit, one cycle after the request
    // answer fields hold until the next answer, so a slow reader still sees them
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_rsp_valid <= 1'b0;
            o_rsp <= '0;
            o_nv_write <= 1'b0;
            o_nv <= '0;
        end else begin
            o_rsp_valid <= answer;
            o_nv_write <= set_pon || set_fsf;
            if (answer) begin
                o_rsp.func <= i_req.func;
                o_rsp.selector <= i_req.selector;
                o_rsp.ack <= 1'b1;
                o_rsp.length <= odc_pkg::PATTERN_LEN;
                o_rsp.data <= is_set ? i_req.data : (hit_pon ? power_on : fail_safe);
            end
            if (set_pon || set_fsf) begin
                o_nv.slot <= set_fsf;
                o_nv.data <= i_req.data;
            end
        end
    end

    // assertion helpers: has the host written each pattern since reset
    logic pon_written;
    logic fsf_written;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pon_written <= 1'b0;
            fsf_written <= 1'b0;
        end else begin
            pon_written <= pon_written || set_pon;
            fsf_written <= fsf_written || set_fsf;
        end
    end

    // mode is not used to drive safe directly; safe_cond has priority in the mux
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_safe_output: assert property (safe_cond |=> o_dout == $past(fail_safe))
        else $error("dout not fail-safe");
    a_boot_holds: assert property (mode == odc_pkg::ODC_BOOT && !safe_cond
        |=> o_dout == $past(boot_value))
        else $error("boot pattern not driven");
    a_pon_no_effect: assert property (set_pon && boot_loaded |=> $stable(boot_value))
        else $error("power-on write changed boot pattern");
    a_fsf_immediate: assert property (set_fsf ##1 safe_cond
        |=> o_dout == $past(i_req.data, 2))
        else $error("fail-safe not used at once");
    a_set_commit: assert property (set_pon |=> o_nv_write && !o_nv.slot)
        else $error("power-on not committed");
    a_fsf_commit: assert property (set_fsf |=> o_nv_write && o_nv.slot)
        else $error("fail-safe not committed");
    a_answer_ack: assert property (answer |=> o_rsp_valid && o_rsp.ack)
        else $error("answer missing");
    a_sel_filter: assert property (i_req_valid && !sel_ok |=> !o_rsp_valid)
        else $error("wrong selector answered");
    a_query_data: assert property (hit_pon && is_query |=> o_rsp.data == $past(power_on))
        else $error("query data wrong");
    a_default_zero: assert property (!boot_loaded && !pon_written
        |-> power_on == odc_pkg::POWER_ON_RESET)
        else $error("power-on default wrong");
    a_fsf_default: assert property (!boot_loaded && !fsf_written
        |-> fail_safe == odc_pkg::FAIL_SAFE_RESET)
        else $error("fail-safe default wrong");
    // outputs in boot and after a command, leaving boot, answer fields, refusals and commits
    a_run_after_cmd: assert property (i_out_cmd ##1 !safe_cond
        |=> o_dout == $past(i_out_value, 2))
        else $error("output command not driven");
    a_analog_boot: assert property (mode == odc_pkg::ODC_BOOT
        |=> o_analog_output == $past(boot_value))
        else $error("analog boot pattern wrong");
    a_boot_once: assert property (mode != odc_pkg::ODC_BOOT
        |=> mode != odc_pkg::ODC_BOOT)
        else $error("boot pattern came back");
    a_rsp_shape: assert property (answer
        |=> o_rsp.length == odc_pkg::PATTERN_LEN && o_rsp.selector == odc_pkg::SEL_DOUT)
        else $error("answer shape wrong");
    a_set_echo: assert property (answer && is_set
        |=> o_rsp.data == $past(i_req.data))
        else $error("set answer data wrong");
    a_fsf_query: assert property (hit_fsf && is_query
        |=> o_rsp.data == $past(fail_safe))
        else $error("fail-safe query data wrong");
    a_refuse_len: assert property (i_req_valid && !is_set && !is_query
        |=> !o_rsp_valid && !o_nv_write)
        else $error("malformed frame answered");
    a_query_no_write: assert property (i_req_valid && i_req.remote
        |=> !o_nv_write)
        else $error("query wrote memory");
    a_nv_data: assert property (set_pon || set_fsf
        |=> o_nv.data == $past(i_req.data))
        else $error("committed data wrong");

    // main scenarios the bench is expected to reach
    c_set_pon: cover property (set_pon);
    c_query_fsf: cover property (hit_fsf && is_query);
    c_enter_safe: cover property (!safe_cond ##1 safe_cond);
    c_leave_boot: cover property (mode == odc_pkg::ODC_BOOT ##1 mode == odc_pkg::ODC_RUN);
    c_safe_run: cover property (mode == odc_pkg::ODC_RUN && safe_cond);
endmodule

// >>> odc_pkg.sv
package odc_pkg;
    // function codes carried in the identifier
    localparam logic [7:0] FUNC_POWER_ON = 8'h60;
    localparam logic [7:0] FUNC_FAIL_SAFE = 8'h61;
    // selector field values
    localparam logic [7:0] SEL_ALL_IO = 8'h00;
    localparam logic [7:0] SEL_DOUT = 8'h01;
    localparam logic [7:0] SEL_DIN = 8'h02;
    // factory defaults of both stored patterns
    localparam logic [7:0] POWER_ON_RESET = 8'h00;
    localparam logic [7:0] FAIL_SAFE_RESET = 8'h00;
    localparam logic [3:0] PATTERN_LEN = 4'h1;

    // decoded request from the frame controller
    typedef struct packed {
        logic [7:0] func;
        logic [7:0] selector;
        logic remote;
        logic [3:0] length;
        logic [7:0] data;
    } odc_req_s;

    // answer frame handed back to the frame controller
    typedef struct packed {
        logic [7:0] func;
        logic [7:0] selector;
        logic ack;
        logic [3:0] length;
        logic [7:0] data;
    } odc_rsp_s;

    // nonvolatile write request
    typedef struct packed {
        logic slot;
        logic [7:0] data;
    } odc_nv_s;

    typedef enum logic [2:0] {
        ODC_BOOT = 3'b001,
        ODC_RUN = 3'b010,
        ODC_SAFE = 3'b100
    } odc_mode_e;
endpackage

// >>> odc_host.sv
module odc_host (
    input wire logic i_clock, // system clock
    input wire logic i_rsp_valid, // answer strobe from the block
    input wire odc_pkg::odc_rsp_s i_rsp, // answer frame
    output odc_pkg::odc_req_s o_req, // request toward the block
    output logic o_req_valid // request strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus before the first frame
    initial begin
        o_req_valid = 1'b0;
        o_req = '0;
    end
    // one frame per call; the answer is due one edge after the taking edge
    task automatic xfer(input logic [7:0] func, input logic [7:0] sel, input logic remote,
            input logic [3:0] len, input logic [7:0] data, output logic seen,
            output odc_pkg::odc_rsp_s rsp);
        @(negedge i_clock);
        o_req = {func, sel, remote, len, data};
        o_req_valid = 1'b1;
        @(negedge i_clock);
        o_req_valid = 1'b0;
        o_req = ~o_req; // released fields must not keep their old value
        seen = i_rsp_valid;
        rsp = i_rsp;
    endtask
endmodule

// >>> tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock, i_rst, i_req_valid, i_nv_valid, i_out_cmd, i_stalled, i_heartbeat_lost;
    logic o_rsp_valid, o_nv_write, seen;
    logic [7:0] i_nv_power_on, i_nv_fail_safe, i_out_value, o_dout, o_analog_output;
    odc_pkg::odc_req_s i_req;
    odc_pkg::odc_rsp_s o_rsp, rsp;
    odc_pkg::odc_nv_s o_nv;
    int failures = 0;
    int total_checks = 0;
    odc_config u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_req_valid(i_req_valid),
        .i_req(i_req), .i_nv_valid(i_nv_valid), .i_nv_power_on(i_nv_power_on),
        .i_nv_fail_safe(i_nv_fail_safe), .i_out_cmd(i_out_cmd), .i_out_value(i_out_value),
        .i_stalled(i_stalled), .i_heartbeat_lost(i_heartbeat_lost), .o_rsp_valid(o_rsp_valid),
        .o_rsp(o_rsp), .o_nv_write(o_nv_write), .o_nv(o_nv), .o_dout(o_dout),
        .o_analog_output(o_analog_output));
    odc_host u_host (.i_clock(i_clock), .i_rsp_valid(o_rsp_valid), .i_rsp(o_rsp),
        .o_req(i_req), .o_req_valid(i_req_valid));
    // 100 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // outputs are registered, so give them two full cycles to land
    task automatic outs(input logic [7:0] dout, input logic [7:0] ana);
        repeat (2) @(negedge i_clock);
        chk("dout", dout, o_dout);
        chk("analog", ana, o_analog_output);
    endtask
    task automatic ask(input logic [7:0] func, input logic remote, input logic [7:0] data,
            input logic [7:0] exp);
        u_host.xfer(func, odc_pkg::SEL_DOUT, remote, odc_pkg::PATTERN_LEN, data, seen, rsp);
        chk("answer", 8'h01, {7'h00, seen});
        chk("ack", 8'h01, {7'h00, rsp.ack});
        chk("rsp func", func, rsp.func);
        chk("rsp sel", odc_pkg::SEL_DOUT, rsp.selector);
        chk("rsp len", {4'h0, odc_pkg::PATTERN_LEN}, {4'h0, rsp.length});
        chk("rsp data", exp, rsp.data);
        chk("nv write", {7'h00, !remote}, {7'h00, o_nv_write});
        if (!remote) chk("nv data", data, o_nv.data);
        if (!remote) chk("nv slot", {7'h00, func[0]}, {7'h00, o_nv.slot});
    endtask
    task automatic t_boot();
        chk("dout pre", 8'h00, o_dout);
        ask(odc_pkg::FUNC_POWER_ON, 1'b1, 8'h00, 8'h00);
        ask(odc_pkg::FUNC_FAIL_SAFE, 1'b1, 8'h00, 8'h00);
        i_nv_valid = 1'b1;
        outs(8'h5A, 8'h5A);
        i_stalled = 1'b1;
        outs(8'h00, 8'h5A);
        i_stalled = 1'b0;
        outs(8'h5A, 8'h5A);
    endtask
    task automatic t_patterns();
        ask(odc_pkg::FUNC_POWER_ON, 1'b0, 8'h07, 8'h07);
        ask(odc_pkg::FUNC_POWER_ON, 1'b1, 8'h00, 8'h07);
        outs(8'h5A, 8'h5A);
        ask(odc_pkg::FUNC_FAIL_SAFE, 1'b0, 8'hE0, 8'hE0);
        ask(odc_pkg::FUNC_FAIL_SAFE, 1'b1, 8'h00, 8'hE0);
        i_heartbeat_lost = 1'b1;
        outs(8'hE0, 8'h5A);
        i_heartbeat_lost = 1'b0;
    endtask
    task automatic t_refuse();
        u_host.xfer(8'h61, odc_pkg::SEL_ALL_IO, 1'b1, 4'h1, 8'h00, seen, rsp);
        chk("sel all", 8'h00, {7'h00, seen});
        u_host.xfer(8'h61, odc_pkg::SEL_DIN, 1'b0, 4'h1, 8'h11, seen, rsp);
        chk("sel din", 8'h00, {7'h00, seen | o_nv_write});
        u_host.xfer(8'h60, odc_pkg::SEL_DOUT, 1'b0, 4'h2, 8'h22, seen, rsp);
        chk("bad len", 8'h00, {7'h00, seen | o_nv_write});
    endtask
    task automatic t_out_cmd();
        @(negedge i_clock);
        i_out_cmd = 1'b1;
        i_out_value = 8'h3C;
        @(negedge i_clock);
        i_out_cmd = 1'b0;
        outs(8'h3C, 8'h3C);
        i_stalled = 1'b1;
        outs(8'hE0, 8'h3C);
        i_stalled = 1'b0;
        outs(8'h3C, 8'h3C);
    endtask
    // a second boot loads what the host committed, so the new power-on value shows now
    task automatic t_reboot();
        i_rst = 1'b1;
        i_nv_valid = 1'b0;
        {i_nv_power_on, i_nv_fail_safe} = {8'h07, 8'hE0};
        repeat (8) @(negedge i_clock);
        chk("dout in reset", 8'h00, o_dout);
        i_rst = 1'b0;
        i_nv_valid = 1'b1;
        outs(8'h07, 8'h07);
        i_heartbeat_lost = 1'b1;
        outs(8'hE0, 8'h07);
        i_heartbeat_lost = 1'b0;
    endtask
    // a hang anywhere ends the run as a mismatch
    initial begin
        repeat (20000) @(posedge i_clock);
        failures++;
        end_sim();
    end
    // reset, then the scenarios in order
    initial begin
        {i_rst, i_nv_valid, i_out_cmd, i_stalled, i_heartbeat_lost} = 5'b10000;
        {i_nv_power_on, i_nv_fail_safe, i_out_value} = {8'h5A, 8'h00, 8'h00};
        repeat (8) @(posedge i_clock);
        @(negedge i_clock);
        i_rst = 1'b0;
        t_boot();
        t_patterns();
        t_refuse();
        t_out_cmd();
        t_reboot();
        end_sim();
    end
endmodule
